// [hw/clb_bridge.sv]
/*
 * Bridge from a simple wait-stalled register port to a character display.
 * Holds the pin sequencer, power-up initialisation, a write queue
 * and a shadow of the display's cursor, shift and cursor style.
 * Assumes the display pins are synchronous to clk and the master holds its
 * request stable while bus_wait is high.
 */
// Summary of operation
// - Two byte registers: command at offset 0 and character at the next slot (offset 4).
// - Command register accesses go to the display with register_select low.
// - Character register accesses go to the display with register_select high.
// - After reset release the display is initialised without software help.
// - All timing is derived from a 50 MHz system clock.
// - A build parameter picks steady, blinking, both or no cursor for initialisation.
// - The display holds two rows of 40 locations, 16 of them visible.
// - Top row uses 0x00-0x0F visible, bottom 0x40-0x4F, bit 6 picks the row.
// - A command with bit 7 set moves the cursor to its low seven bits.
// - Each stored character advances the cursor one place right.
// - Past the 40th top location the cursor goes to 0x40, past the bottom end to 0x00.
// - Commands 0x18 and 0x1C rotate both rows left and right together.
// - Command 0x0C turns the blinking cursor off and 0x0F turns it on.
// - Command 0x01 erases the display and homes the cursor to 0x00.
`timescale 1ns/1ps
module clb_bridge #(
    parameter logic [1:0] CURSOR_STYLE   = clb_pkg::CURSOR_BOTH,
    parameter int         CLEAR_CYCLES   = clb_pkg::CLEAR_CYC,
    parameter int         POWERON_CYCLES = clb_pkg::POWERON_CYC
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [2:0] bus_addr,
    input  wire logic       bus_read,
    input  wire logic       bus_write,
    input  wire logic [7:0] bus_wdata,
    output logic      [7:0] bus_rdata,
    output logic            bus_wait,
    input  wire logic [7:0] lcd_data_in,
    output logic      [7:0] lcd_data_out,
    output logic            lcd_data_oe,
    output logic            register_select,
    output logic            lcd_rw,
    output logic            lcd_enable,
    output logic      [6:0] cursor_addr,
    output logic      [5:0] shift_pos,
    output logic            cursor_visible,
    output logic            cursor_blink,
    output logic            init_done
);
    localparam int CNT_W = 24;

    typedef enum logic [2:0] {X_IDLE, X_SETUP, X_PULSE, X_HOLD, X_EXEC} clb_xfer_e;

    clb_xfer_e        state_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] pwr_cnt_reg;
    logic             pwr_done_reg;
    logic [2:0]       init_idx_reg;
    logic             init_done_reg;
    logic             bus_wait_reg;
    logic             ack_write_reg;
    logic             read_busy_reg;
    logic [7:0]       bus_rdata_reg;
    logic [7:0]       data_out_reg;
    logic             oe_reg;
    logic             rs_reg;
    logic             rw_reg;
    logic             enable_reg;
    logic [6:0]       cursor_reg;
    logic [5:0]       shift_reg;
    logic             visible_reg;
    logic             blink_reg;
    logic             start_go;
    logic             start_rs;
    logic             start_rw;
    logic [7:0]       start_data;
    logic             init_feed;
    logic             fifo_pop;
    logic             read_start;
    logic             write_ok;
    logic             pulse_end;
    logic             hold_end;
    logic             exec_go;
    logic             read_done;
    logic             write_busy_reg;
    logic             exec_end;
    logic             fifo_in_ready;
    logic             fifo_out_valid;
    logic [8:0]       fifo_out_data;

    // Display control byte for the chosen cursor style
    function automatic logic [7:0] ctrl_cmd(input logic [1:0] style);
        logic [7:0] c;
        c = clb_pkg::CMD_CURSOR_OFF;
        c[clb_pkg::CTRL_CURSOR_BIT] = (style == clb_pkg::CURSOR_STEADY) ||
                                      (style == clb_pkg::CURSOR_BOTH);
        c[clb_pkg::CTRL_BLINK_BIT]  = (style == clb_pkg::CURSOR_BLINK) ||
                                      (style == clb_pkg::CURSOR_BOTH);
        ctrl_cmd = c;
    endfunction

    // Power-up command list
    function automatic logic [7:0] init_cmd(input logic [2:0] idx);
        case (idx)
            3'h0:    init_cmd = clb_pkg::CMD_FUNC_SET;
            3'h1:    init_cmd = clb_pkg::CMD_FUNC_SET;
            3'h2:    init_cmd = ctrl_cmd(CURSOR_STYLE);
            3'h3:    init_cmd = clb_pkg::CMD_CLEAR;
            default: init_cmd = clb_pkg::CMD_ENTRY_MODE;
        endcase
    endfunction

    // Cursor step with row wrap
    function automatic logic [6:0] next_cursor(input logic [6:0] a);
        if (a == clb_pkg::TOP_LAST) begin
            next_cursor = clb_pkg::BOTTOM_FIRST;
        end else if (a == clb_pkg::BOTTOM_LAST) begin
            next_cursor = clb_pkg::HOME;
        end else begin
            next_cursor = a + 7'h01;
        end
    endfunction

    // Transfer sources: initialisation, then queued writes, then a read
    assign init_feed  = pwr_done_reg && !init_done_reg && (state_reg == X_IDLE);
    assign fifo_pop   = init_done_reg && (state_reg == X_IDLE) && fifo_out_valid;
    assign read_start = init_done_reg && (state_reg == X_IDLE) && !fifo_out_valid &&
                        bus_read && bus_wait_reg && !read_busy_reg;
    // Writes are taken only into an idle path, so the stall covers their execution
    assign write_ok   = init_done_reg && (state_reg == X_IDLE) && !fifo_out_valid &&
                        bus_write && bus_wait_reg && fifo_in_ready && !ack_write_reg &&
                        !read_busy_reg && !write_busy_reg;

    always_comb begin
        start_go   = 1'b0;
        start_rs   = 1'b0;
        start_rw   = 1'b0;
        start_data = 8'h00;
        if (init_feed) begin
            start_go   = 1'b1;
            start_data = init_cmd(init_idx_reg);
        end else if (fifo_pop) begin
            start_go   = 1'b1;
            start_rs   = fifo_out_data[8];
            start_data = fifo_out_data[7:0];
        end else if (read_start) begin
            start_go = 1'b1;
            start_rs = bus_addr[clb_pkg::SEL_BIT];
            start_rw = 1'b1;
        end
    end

    assign pulse_end = (state_reg == X_PULSE) && (cnt_reg == '0);
    assign hold_end  = (state_reg == X_HOLD) && (cnt_reg == '0);
    assign exec_go   = hold_end && !rw_reg;
    assign read_done = hold_end && rw_reg;
    assign exec_end  = (state_reg == X_EXEC) && (cnt_reg == '0);

    // Power-up wait before the first command
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwr_cnt_reg  <= '0;
            pwr_done_reg <= 1'b0;
        end else if (!pwr_done_reg) begin
            if (pwr_cnt_reg == CNT_W'(POWERON_CYCLES - 1)) begin
                pwr_done_reg <= 1'b1;
            end else begin
                pwr_cnt_reg <= pwr_cnt_reg + CNT_W'(1);
            end
        end
    end

    // Initialisation step counter
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            init_idx_reg  <= 3'h0;
            init_done_reg <= 1'b0;
        end else if (init_feed) begin
            init_idx_reg <= init_idx_reg + 3'h1;
            if (init_idx_reg == clb_pkg::INIT_STEPS - 3'h1) begin
                init_done_reg <= 1'b1;
            end
        end
    end

    // Pin sequencer: setup, enable pulse, hold, then execution wait for writes only
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg    <= X_IDLE;
            cnt_reg      <= '0;
            enable_reg   <= 1'b0;
            rs_reg       <= 1'b0;
            rw_reg       <= 1'b0;
            oe_reg       <= 1'b0;
            data_out_reg <= 8'h00;
        end else begin
            case (state_reg)
                X_IDLE: begin
                    if (start_go) begin
                        rs_reg       <= start_rs;
                        rw_reg       <= start_rw;
                        oe_reg       <= !start_rw;
                        data_out_reg <= start_data;
                        cnt_reg      <= CNT_W'(clb_pkg::SETUP_CYC - 1);
                        state_reg    <= X_SETUP;
                    end
                end
                X_SETUP: begin
                    if (cnt_reg == '0) begin
                        enable_reg <= 1'b1;
                        cnt_reg    <= CNT_W'(clb_pkg::PULSE_CYC - 1);
                        state_reg  <= X_PULSE;
                    end else begin
                        cnt_reg <= cnt_reg - CNT_W'(1);
                    end
                end
                X_PULSE: begin
                    if (cnt_reg == '0) begin
                        enable_reg <= 1'b0;
                        cnt_reg    <= CNT_W'(clb_pkg::HOLD_CYC - 1);
                        state_reg  <= X_HOLD;
                    end else begin
                        cnt_reg <= cnt_reg - CNT_W'(1);
                    end
                end
                X_HOLD: begin
                    if (cnt_reg == '0) begin
                        oe_reg <= 1'b0;
                        if (rw_reg) begin
                            state_reg <= X_IDLE;
                        end else begin
                            // Clear runs much longer than other commands
                            if (!rs_reg && data_out_reg == clb_pkg::CMD_CLEAR) begin
                                cnt_reg <= CNT_W'(CLEAR_CYCLES - 1);
                            end else begin
                                cnt_reg <= CNT_W'(clb_pkg::CMD_CYC - 1);
                            end
                            state_reg <= X_EXEC;
                        end
                    end else begin
                        cnt_reg <= cnt_reg - CNT_W'(1);
                    end
                end
                default: begin
                    if (cnt_reg == '0) begin
                        state_reg <= X_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - CNT_W'(1);
                    end
                end
            endcase
        end
    end

    // Bus handshake: wait low for one cycle completes the access
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_wait_reg   <= 1'b1;
            ack_write_reg  <= 1'b0;
            read_busy_reg  <= 1'b0;
            write_busy_reg <= 1'b0;
        end else begin
            ack_write_reg <= write_ok;
            if (!bus_wait_reg) begin
                bus_wait_reg <= 1'b1;
            end else if ((write_busy_reg && exec_end) || read_done) begin
                bus_wait_reg <= 1'b0;
            end
            // A write stays open until the display has executed it
            if (write_ok) begin
                write_busy_reg <= 1'b1;
            end else if (exec_end) begin
                write_busy_reg <= 1'b0;
            end
            if (read_start) begin
                read_busy_reg <= 1'b1;
            end else if (read_done) begin
                read_busy_reg <= 1'b0;
            end
        end
    end

    // Read data caught at the falling edge of enable
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_rdata_reg <= 8'h00;
        end else if (pulse_end && rw_reg) begin
            bus_rdata_reg <= lcd_data_in;
        end
    end

    // Shadow cursor address
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cursor_reg <= clb_pkg::HOME;
        end else if (exec_go) begin
            if (rs_reg) begin
                cursor_reg <= next_cursor(cursor_reg);
            end else if (data_out_reg[clb_pkg::SET_ADDR_BIT]) begin
                cursor_reg <= data_out_reg[6:0];
            end else if (data_out_reg == clb_pkg::CMD_CLEAR) begin
                cursor_reg <= clb_pkg::HOME;
            end
        end
    end

    // Shadow row rotation, modulo the row length
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_reg <= 6'h00;
        end else if (exec_go && !rs_reg) begin
            if (data_out_reg == clb_pkg::CMD_CLEAR) begin
                shift_reg <= 6'h00;
            end else if (data_out_reg == clb_pkg::CMD_SHIFT_LEFT) begin
                shift_reg <= (shift_reg == 6'(clb_pkg::ROW_LEN - 1)) ? 6'h00
                             : shift_reg + 6'h01;
            end else if (data_out_reg == clb_pkg::CMD_SHIFT_RIGHT) begin
                shift_reg <= (shift_reg == 6'h00) ? 6'(clb_pkg::ROW_LEN - 1)
                             : shift_reg - 6'h01;
            end
        end
    end

    // Shadow cursor style from display control commands
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            visible_reg <= 1'b0;
            blink_reg   <= 1'b0;
        end else if (exec_go && !rs_reg && data_out_reg[7:3] == clb_pkg::CTRL_PREFIX) begin
            visible_reg <= data_out_reg[clb_pkg::CTRL_CURSOR_BIT];
            blink_reg   <= data_out_reg[clb_pkg::CTRL_BLINK_BIT];
        end
    end

    // Write queue in front of the sequencer
    clb_fifo #(
        .WIDTH (clb_pkg::FIFO_WIDTH),
        .DEPTH (clb_pkg::FIFO_DEPTH)
    ) u_queue (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_data   ({bus_addr[clb_pkg::SEL_BIT], bus_wdata}),
        .in_valid  (ack_write_reg),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop)
    );

    // Outputs straight from flops
    assign bus_rdata       = bus_rdata_reg;
    assign bus_wait        = bus_wait_reg;
    assign lcd_data_out    = data_out_reg;
    assign lcd_data_oe     = oe_reg;
    assign register_select = rs_reg;
    assign lcd_rw          = rw_reg;
    assign lcd_enable      = enable_reg;
    assign cursor_addr     = cursor_reg;
    assign shift_pos       = shift_reg;
    assign cursor_visible  = visible_reg;
    assign cursor_blink    = blink_reg;
    assign init_done       = init_done_reg;

    // Checks on the guarded behaviour
    a_init_stalls_bus: assert property (@(posedge clk) disable iff (sys_rst)
        !init_done_reg |-> bus_wait_reg) else $error("bus completed during init");
    a_init_first_cmd: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(pwr_done_reg) |-> ##1 (oe_reg && !rs_reg &&
        data_out_reg == clb_pkg::CMD_FUNC_SET)) else $error("init did not start");
    a_cmd_select_low: assert property (@(posedge clk) disable iff (sys_rst)
        (bus_read && !bus_wait_reg && !bus_addr[clb_pkg::SEL_BIT]) |-> !rs_reg)
        else $error("command read with select high");
    a_char_select_high: assert property (@(posedge clk) disable iff (sys_rst)
        (fifo_pop && fifo_out_data[8]) |=> rs_reg) else $error("char with select low");
    a_set_cursor_addr: assert property (@(posedge clk) disable iff (sys_rst)
        (exec_go && !rs_reg && data_out_reg[7]) |=> cursor_reg == $past(data_out_reg[6:0]))
        else $error("set address not taken");
    a_top_row_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        (exec_go && rs_reg && cursor_reg == 7'h27) |=> cursor_reg == 7'h40)
        else $error("top row wrap wrong");
    a_bottom_row_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        (exec_go && rs_reg && cursor_reg == 7'h67) |=> cursor_reg == 7'h00)
        else $error("bottom row wrap wrong");
    a_char_advance: assert property (@(posedge clk) disable iff (sys_rst)
        (exec_go && rs_reg && cursor_reg == 7'h05) |=> cursor_reg == 7'h06)
        else $error("cursor did not advance");
    a_shift_rotate: assert property (@(posedge clk) disable iff (sys_rst)
        (exec_go && !rs_reg && data_out_reg == 8'h18 && shift_reg == 6'h27) |=>
        shift_reg == 6'h00) else $error("left rotate wrong");
    a_blink_off: assert property (@(posedge clk) disable iff (sys_rst)
        (exec_go && !rs_reg && data_out_reg == 8'h0C) |=> !blink_reg && !visible_reg)
        else $error("cursor still on");
    a_clear_home: assert property (@(posedge clk) disable iff (sys_rst)
        (exec_go && !rs_reg && data_out_reg == 8'h01) |=> cursor_reg == 7'h00 &&
        shift_reg == 6'h00) else $error("clear did not home");
    a_enable_width: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(enable_reg) |-> enable_reg [*7] ##1 !enable_reg)
        else $error("enable pulse width wrong");

endmodule

// [hw/clb_pkg.sv]
/*
 * Shared constants of the character display bridge: register offsets,
 * display command codes, cursor styles, addressing and pin timing.
 * Assumes a single system clock of the rate given here.
 */
package clb_pkg;

    // Register byte offsets; bit 2 of the byte address picks the register
    localparam logic [2:0] ADDR_COMMAND   = 3'h0;
    localparam logic [2:0] ADDR_CHARACTER = 3'h4;
    localparam int         SEL_BIT        = 2;

    // Clock the timing is derived from
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;

    // Pin and execution times in their own units
    localparam int T_SETUP_NS   = 60;
    localparam int T_PULSE_NS   = 140;
    localparam int T_HOLD_NS    = 20;
    localparam int T_CMD_US     = 40;
    localparam int T_CLEAR_US   = 1640;
    localparam int T_POWERON_US = 15000;

    // Cycle counts, least times rounded up
    localparam int SETUP_CYC   = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_CYC   = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC    = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CMD_CYC     = T_CMD_US * (CLK_HZ / 1_000_000);
    localparam int CLEAR_CYC   = T_CLEAR_US * (CLK_HZ / 1_000_000);
    localparam int POWERON_CYC = T_POWERON_US * (CLK_HZ / 1_000_000);

    // Cursor styles chosen at build time
    localparam logic [1:0] CURSOR_STEADY = 2'h0;
    localparam logic [1:0] CURSOR_BLINK  = 2'h1;
    localparam logic [1:0] CURSOR_BOTH   = 2'h2;
    localparam logic [1:0] CURSOR_NONE   = 2'h3;

    // Display command codes and fields
    localparam logic [7:0] CMD_CLEAR       = 8'h01;
    localparam logic [7:0] CMD_ENTRY_MODE  = 8'h06;
    localparam logic [7:0] CMD_CURSOR_OFF  = 8'h0C;
    localparam logic [7:0] CMD_BLINK_ON    = 8'h0F;
    localparam logic [7:0] CMD_SHIFT_LEFT  = 8'h18;
    localparam logic [7:0] CMD_SHIFT_RIGHT = 8'h1C;
    localparam logic [7:0] CMD_FUNC_SET    = 8'h38;
    localparam logic [4:0] CTRL_PREFIX     = 5'h01;
    localparam int         CTRL_CURSOR_BIT = 1;
    localparam int         CTRL_BLINK_BIT  = 0;
    localparam int         SET_ADDR_BIT    = 7;
    localparam logic [2:0] INIT_STEPS      = 3'h5;

    // Display addressing: two rows of 40, bit 6 picks the row
    localparam int         ROW_LEN      = 40;
    localparam int         ROW_BIT      = 6;
    localparam logic [6:0] HOME         = 7'h00;
    localparam logic [6:0] TOP_LAST     = 7'h27;
    localparam logic [6:0] BOTTOM_FIRST = 7'h40;
    localparam logic [6:0] BOTTOM_LAST  = 7'h67;

    // Write queue shape: select bit plus one byte
    localparam int FIFO_WIDTH = 9;
    localparam int FIFO_DEPTH = 8;

endpackage

// [hw/clb_fifo.sv]
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
module clb_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        if (p == AW'(DEPTH - 1)) begin
            bump = '0;
        end else begin
            bump = p + AW'(1);
        end
    endfunction

    assign push = in_valid && in_ready;
    assign pop  = out_valid && out_ready;

    // Storage written on accepted input
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= bump(wr_ptr_reg);
            end
            if (pop) begin
                rd_ptr_reg <= bump(rd_ptr_reg);
            end
            if (push && !pop) begin
                count_reg <= count_reg + (AW+1)'(1);
            end else if (pop && !push) begin
                count_reg <= count_reg - (AW+1)'(1);
            end
        end
    end

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_ptr_reg];

endmodule

// [tb/clb_display_model.sv]
/* Behavioural display, two rows of 40 cells.
   Assumes pins that move with the bridge clock. */
`timescale 1ns/1ps
module clb_display_model (
    input  wire logic       lcd_enable,
    input  wire logic       register_select,
    input  wire logic       lcd_rw,
    input  wire logic [7:0] lcd_data_out,
    output logic      [7:0] lcd_data_in
);
    logic [7:0] mem [128];
    logic [6:0] addr = 7'h00;
    logic [7:0] rd_val;
    logic [7:0] last_cmd;
    int         cmd_count = 0;
    logic       armed = 1'b0;
    // Read value, inverted while the pins are released
    assign rd_val = register_select ? mem[addr] : {1'b0, addr};
    assign lcd_data_in = (lcd_enable && lcd_rw) ? rd_val : ~rd_val;
    // Arm on a real rising strobe so the reset step out of X is not taken
    always @(posedge lcd_enable) armed = 1'b1;
    // Take each write at the end of its strobe
    always @(negedge lcd_enable) begin
        if (armed && lcd_rw === 1'b0 && register_select === 1'b0) begin
            last_cmd = lcd_data_out;
            cmd_count++;
            if (lcd_data_out[7]) addr = lcd_data_out[6:0];
            if (lcd_data_out == 8'h01) addr = 7'h00;
        end else if (armed && lcd_rw === 1'b0) begin
            mem[addr] = lcd_data_out;
            addr = (addr == 7'h27) ? 7'h40 : (addr == 7'h67) ? 7'h00 : addr + 7'h01;
        end
    end
endmodule

// [tb/test_clb_bridge.sv]
/* Self-checking bench of the display bridge.
   Assumes shortened power-up and clear waits. */
`timescale 1ns/1ps
module test_clb_bridge;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic [2:0] bus_addr = 3'h0;
    logic       bus_read = 1'b0;
    logic       bus_write = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic [7:0] bus_rdata, lcd_data_in, lcd_data_out, rd;
    logic       bus_wait, lcd_data_oe, register_select, lcd_rw, lcd_enable;
    logic [6:0] cursor_addr;
    logic [5:0] shift_pos;
    logic       cursor_visible, cursor_blink, init_done;
    int         bad_count = 0;
    int         checks = 0;
    int         waited, most;
    logic [7:0] cmd_tab [6] = '{8'h18, 8'h1C, 8'h1C, 8'h0C, 8'h0F, 8'h18};
    logic [7:0] exp_tab [6] = '{8'h07, 8'h03, 8'h9F, 8'h9C, 8'h9F, 8'h03};
    always #50 clk = ~clk;
    clb_bridge #(.POWERON_CYCLES(20), .CLEAR_CYCLES(10)) dut_u (.clk(clk), .sys_rst(sys_rst),
        .bus_addr(bus_addr), .bus_read(bus_read), .bus_write(bus_write), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_wait(bus_wait), .lcd_data_in(lcd_data_in),
        .lcd_data_out(lcd_data_out), .lcd_data_oe(lcd_data_oe), .lcd_enable(lcd_enable),
        .register_select(register_select), .lcd_rw(lcd_rw), .cursor_addr(cursor_addr),
        .shift_pos(shift_pos), .cursor_visible(cursor_visible), .cursor_blink(cursor_blink),
        .init_done(init_done));
    clb_display_model disp_u (.lcd_enable(lcd_enable), .register_select(register_select),
        .lcd_rw(lcd_rw), .lcd_data_out(lcd_data_out), .lcd_data_in(lcd_data_in));
    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One bus access, held until the stall drops
    task automatic acc(input logic rd_en, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        #5;
        waited = 0;
        bus_addr = a;
        bus_wdata = d;
        bus_read = rd_en;
        bus_write = !rd_en;
        do begin
            @(posedge clk);
            waited++;
        end while (bus_wait !== 1'b0 && waited < 20000);
        rd = bus_rdata;
        if (waited >= 20000) begin
            $display("MISMATCH t=%0t bus access timed out", $time);
            bad_count++;
            finish_test();
        end
        #5;
        bus_read = 1'b0;
        bus_write = 1'b0;
    endtask
    // Power-up sequence runs alone
    task automatic init_test;
        for (int i = 0; i < 20000 && init_done !== 1'b1; i++) @(posedge clk);
        chk({7'h00, init_done}, 8'h01);
        if (init_done !== 1'b1) finish_test();
        acc(1'b1, 3'h0, 8'h00);
        chk(disp_u.cmd_count[7:0], 8'h05);
        chk(disp_u.last_cmd, 8'h06);
        chk({6'h00, cursor_visible, cursor_blink}, 8'h03);
        chk({7'h00, register_select}, 8'h00);
        $display("init_test done");
    endtask
    // Row ends carry the cursor on
    task automatic wrap_test;
        acc(1'b0, 3'h0, 8'hA7);
        acc(1'b0, 3'h4, 8'h41);
        acc(1'b1, 3'h0, 8'h00);
        chk({1'b0, cursor_addr}, 8'h40);
        chk(rd, 8'h40);
        acc(1'b0, 3'h0, 8'hE7);
        acc(1'b0, 3'h4, 8'h42);
        acc(1'b1, 3'h0, 8'h00);
        chk({1'b0, cursor_addr}, 8'h00);
        acc(1'b0, 3'h0, 8'hA7);
        acc(1'b1, 3'h4, 8'h00);
        chk(rd, 8'h41);
        chk({7'h00, register_select}, 8'h01);
        chk({6'h00, lcd_rw, lcd_data_oe}, 8'h02);
        $display("wrap_test done");
    endtask
    // Each write stalls until the display has executed it
    task automatic fifo_test;
        most = 0;
        acc(1'b0, 3'h0, 8'h80);
        for (int i = 0; i < 10; i++) begin
            acc(1'b0, 3'h4, 8'h30 + i[7:0]);
            if (waited > most) most = waited;
        end
        chk({7'h00, most > clb_pkg::CMD_CYC}, 8'h01);
        acc(1'b1, 3'h0, 8'h00);
        chk({1'b0, cursor_addr}, 8'h0A);
        $display("fifo_test done");
    endtask
    // Shift, cursor style and clear commands
    task automatic cmd_test;
        for (int i = 0; i < 6; i++) begin
            acc(1'b0, 3'h0, cmd_tab[i]);
            acc(1'b1, 3'h0, 8'h00);
            chk({shift_pos, cursor_visible, cursor_blink}, exp_tab[i]);
        end
        acc(1'b0, 3'h0, 8'h85);
        acc(1'b0, 3'h0, 8'h01);
        acc(1'b1, 3'h0, 8'h00);
        chk({1'b0, cursor_addr}, 8'h00);
        chk({2'b00, shift_pos}, 8'h00);
        $display("cmd_test done");
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        #5;
        sys_rst = 1'b0;
        init_test();
        wrap_test();
        fifo_test();
        cmd_test();
        finish_test();
    end
endmodule
